// File: boot_protect.sv
/*
  Boot source selection and on-chip program memory protection.
  Holds the strap synchroniser and boot bank choice, the security byte with
  its one-way programming, lock gating of programmer accesses, the code
  table read restriction, port 0 encoding and the oscillator gain control.
  Assumes: the flash array answers flash_rdata combinationally in the cycle
  of flash_rd; the nonvolatile security value is stable on sec_nv_value
  while rst is high; prog_mode and bank pulses come from logic on clk.
*/
`timescale 1ns/100ps

// Behaviour
// - No strap asserted: boot main code bank
// - Reboot when straps A and B low, or C low
// - Reboot mode starts from loader code bank
// - Programming mode: program and verify until protected
// - Security byte accessible only in programming mode
// - Security byte at loader bank top address
// - Programmed security bit cannot change again
// - Only erase-all returns security bits high
// - Lock low denies memory and security access
// - Inhibit low: external code reads stay external
// - Internal code reads may always reach internal
// - Inhibit high: no code read restriction
// - Encryption enabled: port 0 data encoded
// - Encryption cleared only by whole-chip erase
// - Bit seven low halves oscillator gain
// - Read-only flag shows loader bank running
module boot_protect #(
  parameter logic [7:0] ENC_KEY = 8'h5A // Arbitrary encoding key
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Reboot strap pins
  input wire boot_protect_pkg::straps_s strap_pins,
  // Nonvolatile security byte store
  input wire logic [7:0] sec_nv_value,
  output logic [7:0] sec_nv_wdata,
  output logic sec_nv_we,
  // Programmer access port
  input wire logic prog_mode,
  input wire boot_protect_pkg::prog_req_s prog_req,
  input wire logic erase_all,
  output logic [7:0] prog_rdata,
  // Flash array strobes
  output logic flash_wr,
  output logic flash_rd,
  output logic flash_erase,
  input wire logic [7:0] flash_rdata,
  // Boot bank selection
  input wire logic bank_to_loader,
  input wire logic bank_to_main,
  output logic boot_valid,
  output logic running_loader_flag,
  // Code table read steering
  input wire logic code_table_read_instruction_exec_external,
  output logic code_table_read_instruction_internal_ok,
  // Port 0 data path
  input wire logic [7:0] p0_data,
  input wire logic p0_drive,
  output logic [7:0] p0_out,
  output logic p0_oe,
  // Oscillator and status
  output logic osc_half_gain,
  output logic lock_active
);

  // Strap synchroniser stages; stage one feeds stage two only
  logic [2:0] strap_s1_r;
  logic [2:0] strap_s2_r;
  logic [2:0] strap_s3_r;
  logic straps_agree;
  logic reboot_req;

  // Boot sequencing
  boot_protect_pkg::boot_state_e state_r;
  logic [1:0] settle_cnt_r;
  logic loader_r;

  // Security byte and access qualifiers
  logic [7:0] sec_r;
  logic sec_hit;
  logic mem_ok;
  logic sec_ok;
  logic [7:0] rdata_r;
  logic nv_we_r;

  // Output stage registers
  logic [7:0] p0_out_r;
  logic p0_oe_r;
  logic half_gain_r;

  // Encoding applied to port 0 data: key mix then nibble swap
  function automatic logic [7:0] encode_byte(input logic [7:0] d);
    logic [7:0] mixed;
    mixed = d ^ ENC_KEY;
    return {mixed[3:0], mixed[7:4]};
  endfunction : encode_byte

  // Three-stage strap synchroniser, one lane per strap
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          strap_s1_r[gi] <= boot_protect_pkg::STRAPS_IDLE[gi];
          strap_s2_r[gi] <= boot_protect_pkg::STRAPS_IDLE[gi];
          strap_s3_r[gi] <= boot_protect_pkg::STRAPS_IDLE[gi];
        end
        else
        begin
          strap_s1_r[gi] <= strap_pins[gi];
          strap_s2_r[gi] <= strap_s1_r[gi];
          strap_s3_r[gi] <= strap_s2_r[gi];
        end
      end
    end
  endgenerate

  // A strap level counts only once stages two and three agree
  assign straps_agree = (strap_s2_r == strap_s3_r);

  // Bit order follows straps_s: {c, a, b}; all active low
  assign reboot_req = (!strap_s3_r[1] && !strap_s3_r[0])
    || !strap_s3_r[2];

  // Boot sequencer: wait for the pipeline, sample once, then run
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= boot_protect_pkg::ST_HOLD;
      settle_cnt_r <= 2'h0;
    end
    else
    begin
      unique case (state_r)
        boot_protect_pkg::ST_HOLD:
        begin
          state_r <= boot_protect_pkg::ST_SETTLE;
          settle_cnt_r <= 2'h1;
        end
        boot_protect_pkg::ST_SETTLE:
        begin
          // Straps read once; later strap motion is ignored
          if (settle_cnt_r == boot_protect_pkg::SETTLE_CYCLES && straps_agree)
          begin
            state_r <= boot_protect_pkg::ST_RUN;
          end
          else if (settle_cnt_r != boot_protect_pkg::SETTLE_CYCLES)
          begin
            settle_cnt_r <= settle_cnt_r + 2'h1;
          end
        end
        boot_protect_pkg::ST_RUN:
          // Held until the next reset
          state_r <= boot_protect_pkg::ST_RUN;
        // Illegal code recovers through a fresh sample
        default:
          state_r <= boot_protect_pkg::ST_HOLD;
      endcase
    end
  end

  // Bank currently executing; strap choice first, then core switches
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      loader_r <= 1'b0;
    end
    else if (state_r == boot_protect_pkg::ST_SETTLE)
    begin
      if (settle_cnt_r == boot_protect_pkg::SETTLE_CYCLES && straps_agree)
      begin
        loader_r <= reboot_req;
      end
    end
    else if (state_r == boot_protect_pkg::ST_RUN)
    begin
      // Entering the loader wins a clash, so a repair path stays open
      if (bank_to_loader)
      begin
        loader_r <= 1'b1;
      end
      else if (bank_to_main)
      begin
        loader_r <= 1'b0;
      end
    end
  end

  assign boot_valid = (state_r == boot_protect_pkg::ST_RUN);
  assign running_loader_flag = loader_r;

  // Access qualifiers for the programmer port
  assign sec_hit = prog_req.loader_space
    && (prog_req.addr == boot_protect_pkg::SEC_BYTE_ADDR);
  assign lock_active = !sec_r[boot_protect_pkg::LOCK_BIT];
  assign mem_ok = prog_mode && !lock_active;
  assign sec_ok = prog_mode && !lock_active;

  // Flash strobes pass only when the array is open
  assign flash_wr = mem_ok && prog_req.wr && !sec_hit;
  assign flash_rd = mem_ok && prog_req.rd && !sec_hit;
  // Erase-all is never blocked by the lock; it is the way back
  assign flash_erase = prog_mode && erase_all;

  // Security byte: loaded from the store at reset, bits only fall until erase-all sets them high
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sec_r <= sec_nv_value;
    end
    else if (prog_mode && erase_all)
    begin
      sec_r <= boot_protect_pkg::SEC_ERASED;
    end
    else if (sec_ok && prog_req.wr && sec_hit)
    begin
      // AND keeps programmed zeros; writing one cannot restore a bit
      sec_r <= sec_r & prog_req.wdata;
    end
  end

  // Store write pulse follows every change of the security byte
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      nv_we_r <= 1'b0;
    end
    else
    begin
      nv_we_r <= (prog_mode && erase_all)
        || (sec_ok && prog_req.wr && sec_hit);
    end
  end

  assign sec_nv_we = nv_we_r;
  assign sec_nv_wdata = sec_r;

  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_r <= boot_protect_pkg::IDLE_READ;
    end
    else if (!prog_req.rd)
    begin
      rdata_r <= boot_protect_pkg::IDLE_READ;
    end
    else if (sec_hit)
    begin
      // Denied reads return a fixed pattern, never the stored bits
      rdata_r <= sec_ok ? sec_r : boot_protect_pkg::DENIED_READ;
    end
    else
    begin
      rdata_r <= mem_ok ? flash_rdata : boot_protect_pkg::DENIED_READ;
    end
  end

  assign prog_rdata = rdata_r;

  // Code table reads from external code lose internal reach when inhibited
  assign code_table_read_instruction_internal_ok = !code_table_read_instruction_exec_external
    || sec_r[boot_protect_pkg::CODE_TABLE_READ_INSTRUCTION_INH_BIT];

  // Port 0 output stage; encoding costs no extra latency
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      p0_out_r <= 8'h00;
      p0_oe_r <= 1'b0;
    end
    else
    begin
      p0_oe_r <= p0_drive;
      if (!sec_r[boot_protect_pkg::ENCRYPT_BIT])
      begin
        p0_out_r <= encode_byte(p0_data);
      end
      else
      begin
        p0_out_r <= p0_data;
      end
    end
  end

  assign p0_out = p0_out_r;
  assign p0_oe = p0_oe_r;

  // Gain control; lower gain may not sustain fast crystals
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      half_gain_r <= 1'b0;
    end
    else
    begin
      half_gain_r <= !sec_r[boot_protect_pkg::OSC_GAIN_BIT];
    end
  end

  assign osc_half_gain = half_gain_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Boot bank choice tracks straps at the sampling edge
  strap_boot_a: assert property (
    (state_r == boot_protect_pkg::ST_SETTLE
      && settle_cnt_r == boot_protect_pkg::SETTLE_CYCLES && straps_agree)
    |=> (loader_r == $past(reboot_req)))
    else $error("boot bank does not follow sampled straps");
  // Decode checked on the flag itself, not against its own expression
  reboot_decode_a: assert property (
    (state_r == boot_protect_pkg::ST_SETTLE
      && settle_cnt_r == boot_protect_pkg::SETTLE_CYCLES && straps_agree)
    |=> (running_loader_flag == (!$past(strap_s3_r[2])
      || ($past(strap_s3_r[1:0]) == 2'b00))))
    else $error("reboot decode wrong");
  loader_start_a: assert property (
    $rose(boot_valid) && $past(reboot_req) |-> running_loader_flag)
    else $error("reboot did not start in loader bank");
  flash_gate_a: assert property (
    (flash_wr || flash_rd) |-> (prog_mode && sec_r[0]))
    else $error("flash strobe outside open programming mode");
  sec_outside_a: assert property (
    (!prog_mode && !erase_all) |=> (sec_r == $past(sec_r)))
    else $error("security byte changed outside programming mode");
  sec_monotone_a: assert property (
    !$past(erase_all) |-> ((sec_r & ~$past(sec_r)) == 8'h00))
    else $error("programmed security bit went high");
  erase_all_a: assert property (
    (prog_mode && erase_all) |=> (sec_r == 8'hFF) ##1 !osc_half_gain)
    else $error("erase-all did not restore unprotected state");
  lock_read_a: assert property (
    (prog_req.rd && lock_active) |=> (prog_rdata == 8'hFF))
    else $error("locked read leaked data");
  code_table_read_instruction_gate_a: assert property (
    (code_table_read_instruction_exec_external && !sec_r[1]) |-> !code_table_read_instruction_internal_ok)
    else $error("external code read reached internal memory");
  port_encode_a: assert property (
    !sec_r[2] |=> (p0_out == encode_byte($past(p0_data))))
    else $error("port 0 data not encoded");
  sample_once_a: assert property (
    (state_r == boot_protect_pkg::ST_RUN && !bank_to_loader && !bank_to_main)
    |=> $stable(running_loader_flag))
    else $error("boot bank moved after sampling");
  boot_reboot_c: cover property ($rose(boot_valid) && running_loader_flag);
  lock_set_c: cover property ($fell(sec_r[0]));
  erase_c: cover property (lock_active ##[1:60] !lock_active);
  code_table_read_instruction_block_c: cover property (code_table_read_instruction_exec_external && !code_table_read_instruction_internal_ok);

endmodule : boot_protect

// File: boot_protect_pkg.sv
/*
  Shared constants and carriers for the boot selection and code protection
  block: security byte location and bit layout, erased value, settle count,
  the boot state encoding and the packed request and strap carriers.
  Assumes a single core clock domain and a synchronous power-on reset.
*/
package boot_protect_pkg;

  // Security byte location inside the loader bank address space
  localparam logic [15:0] SEC_BYTE_ADDR = 16'hFFFF;

  // Security byte bit positions
  localparam int LOCK_BIT = 0;
  localparam int CODE_TABLE_READ_INSTRUCTION_INH_BIT = 1;
  localparam int ENCRYPT_BIT = 2;
  localparam int OSC_GAIN_BIT = 7;

  // Unprogrammed security byte after an erase-all
  localparam logic [7:0] SEC_ERASED = 8'hFF;

  // Value returned for any denied read
  localparam logic [7:0] DENIED_READ = 8'hFF;

  // Idle read data value
  localparam logic [7:0] IDLE_READ = 8'h00;

  // Edges after reset release before the strap pipeline is full
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  // Strap synchroniser reset value: all straps released (high)
  localparam logic [2:0] STRAPS_IDLE = 3'h7;

  // Boot sequencing states
  typedef enum logic [1:0]
  {
    ST_HOLD = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b10
  } boot_state_e;

  // One programmer access
  typedef struct packed
  {
    logic [15:0] addr;
    logic loader_space;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } prog_req_s;

  // Reboot strap pins, active low
  typedef struct packed
  {
    logic strap_c;
    logic strap_a;
    logic strap_b;
  } straps_s;

endpackage : boot_protect_pkg

// File: boot_protect_tb_top.sv
/*
  Self-checking bench for the boot selection and code protection block.
  Assumes the far-side model below and the package constants.
*/
`timescale 1ns/100ps

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end

module boot_protect_tb_top;
  // Arbitrary encoding key
  localparam logic [7:0] KEY = 8'h5A;
  logic clk, rst, prog_mode, erase_all, bank_to_loader, bank_to_main;
  logic code_table_read_instruction_exec_external, p0_drive, sec_nv_we, flash_wr, flash_rd;
  logic flash_erase, boot_valid, running_loader_flag, code_table_read_instruction_internal_ok;
  logic p0_oe, osc_half_gain, lock_active;
  logic [7:0] sec_nv_value, sec_nv_wdata, prog_rdata, flash_rdata;
  logic [7:0] p0_data, p0_out, d;
  boot_protect_pkg::straps_s strap_pins;
  boot_protect_pkg::prog_req_s prog_req;
  int err_total = 0;
  int n_checks = 0;
  // Random source, fixed start for repeatable runs
  logic [31:0] lfsr = 32'hEFFDC5E1;

  boot_protect #(.ENC_KEY(KEY)) DUT (.clk, .rst, .strap_pins,
    .sec_nv_value, .sec_nv_wdata, .sec_nv_we, .prog_mode, .prog_req,
    .erase_all, .prog_rdata, .flash_wr, .flash_rd, .flash_erase,
    .flash_rdata, .bank_to_loader, .bank_to_main, .boot_valid,
    .running_loader_flag, .code_table_read_instruction_exec_external, .code_table_read_instruction_internal_ok,
    .p0_data, .p0_drive, .p0_out, .p0_oe, .osc_half_gain, .lock_active);

  prog_side_model far (.clk, .prog_req, .flash_wr, .flash_rd, .flash_erase,
    .flash_rdata, .sec_nv_wdata, .sec_nv_we, .sec_nv_value);

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd

  // Expected port 0 encoding
  function automatic logic [7:0] enc(logic [7:0] v);
    logic [7:0] x;
    x = v ^ KEY;
    return {x[3:0], x[7:4]};
  endfunction : enc

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // Reset with straps held steady, then let the sample settle
  task automatic boot(logic [2:0] s, int n);
    @(posedge clk);
    rst <= 1'b1;
    strap_pins <= s;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask : boot

  // One programmer access; returns where read data stand
  task automatic acc(logic [15:0] a, logic ls, logic w, logic [7:0] v);
    @(posedge clk);
    prog_req <= '{addr: a, loader_space: ls, wdata: v, wr: w, rd: !w};
    @(posedge clk);
    prog_req <= '0;
    #1;
  endtask : acc

  task automatic sec_rd(logic [7:0] e);
    acc(16'hFFFF, 1'b1, 1'b0, 8'h00);
    `CHK("sec_byte", e, prog_rdata)
  endtask : sec_rd

  // Random port 0 traffic, plain or encoded
  task automatic p0chk(logic e);
    repeat (4)
    begin
      @(posedge clk);
      d = rnd();
      p0_data <= d;
      p0_drive <= d[0];
      @(posedge clk);
      #1;
      `CHK("p0_out", e ? enc(d) : d, p0_out)
      `CHK("p0_oe", d[0], p0_oe)
    end
  endtask : p0chk

  task automatic bank(logic l);
    @(posedge clk);
    bank_to_loader <= l;
    bank_to_main <= !l;
    @(posedge clk);
    bank_to_loader <= 1'b0;
    bank_to_main <= 1'b0;
    #1;
    `CHK("bank_flag", l, running_loader_flag)
  endtask : bank

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    test_done();
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    prog_mode = 1'b0;
    erase_all = 1'b0;
    bank_to_loader = 1'b0;
    bank_to_main = 1'b0;
    code_table_read_instruction_exec_external = 1'b0;
    p0_data = 8'h00;
    p0_drive = 1'b0;
    strap_pins = 3'h7;
    prog_req = '0;
    boot(3'h7, 20);
    // Every strap combination, then straps moved after the sample
    for (int i = 0; i < 8; i++)
    begin
      boot(i[2:0], 2);
      `CHK("boot_valid", 1'b1, boot_valid)
      `CHK("loader", !i[2] || (!i[1] && !i[0]), running_loader_flag)
      @(posedge clk);
      strap_pins <= ~i[2:0];
      repeat (3) @(posedge clk);
      #1;
      `CHK("held", !i[2] || (!i[1] && !i[0]), running_loader_flag)
    end
    `CHK("main_boot", 1'b0, running_loader_flag)
    bank(1'b1);
    bank(1'b0);
    @(posedge clk);
    prog_mode <= 1'b1;
    code_table_read_instruction_exec_external <= 1'b1;
    // Program and verify random bytes, twice over
    for (int k = 0; k < 8; k++)
    begin
      d = rnd();
      acc(16'(k % 4), 1'b0, 1'b1, d);
      acc(16'(k % 4), 1'b0, 1'b0, 8'h00);
      `CHK("flash_rd", d, prog_rdata)
    end
    sec_rd(8'hFF);
    `CHK("code_table_read_instruction_free", 1'b1, code_table_read_instruction_internal_ok)
    p0chk(1'b0);
    acc(16'hFFFF, 1'b1, 1'b1, 8'hFD);
    `CHK("nv_we", 1'b1, sec_nv_we)
    sec_rd(8'hFD);
    `CHK("code_table_read_instruction_ext", 1'b0, code_table_read_instruction_internal_ok)
    @(posedge clk);
    code_table_read_instruction_exec_external <= 1'b0;
    #1;
    `CHK("code_table_read_instruction_int", 1'b1, code_table_read_instruction_internal_ok)
    @(posedge clk);
    prog_mode <= 1'b0;
    acc(16'hFFFF, 1'b1, 1'b1, 8'h00);
    // Reads outside programming mode are refused
    sec_rd(boot_protect_pkg::DENIED_READ);
    acc(16'h0000, 1'b0, 1'b0, 8'h00);
    `CHK("mode_flash", boot_protect_pkg::DENIED_READ, prog_rdata)
    @(posedge clk);
    prog_mode <= 1'b1;
    sec_rd(8'hFD);
    acc(16'hFFFF, 1'b1, 1'b1, 8'hFF);
    sec_rd(8'hFD);
    acc(16'hFFFF, 1'b1, 1'b1, 8'hFB);
    p0chk(1'b1);
    acc(16'hFFFF, 1'b1, 1'b1, 8'h7F);
    repeat (2) @(posedge clk);
    #1;
    `CHK("osc_half", 1'b1, osc_half_gain)
    // Lock last, after verifying
    acc(16'hFFFF, 1'b1, 1'b1, 8'hFE);
    `CHK("lock", 1'b1, lock_active)
    acc(16'h0001, 1'b0, 1'b0, 8'h00);
    `CHK("lock_flash", 8'hFF, prog_rdata)
    sec_rd(8'hFF);
    boot(3'h7, 2);
    `CHK("lock_kept", 1'b1, lock_active)
    p0chk(1'b1);
    @(posedge clk);
    erase_all <= 1'b1;
    code_table_read_instruction_exec_external <= 1'b1;
    @(posedge clk);
    erase_all <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("unlock", 1'b0, lock_active)
    `CHK("osc_full", 1'b0, osc_half_gain)
    `CHK("code_table_read_instruction_open", 1'b1, code_table_read_instruction_internal_ok)
    sec_rd(8'hFF);
    acc(16'h0001, 1'b0, 1'b0, 8'h00);
    `CHK("erased", 8'hFF, prog_rdata)
    p0chk(1'b0);
    test_done();
  end
endmodule : boot_protect_tb_top

// File: prog_side_model.sv
/*
  Far-side model: a small flash array and the nonvolatile store that holds
  the security byte across resets.
  Assumes the block's flash strobes and store pulses are clocked on clk.
*/
`timescale 1ns/100ps

module prog_side_model (
  // Clock
  input wire logic clk,
  // Flash strobes and programmer request
  input wire boot_protect_pkg::prog_req_s prog_req,
  input wire logic flash_wr,
  input wire logic flash_rd,
  input wire logic flash_erase,
  output logic [7:0] flash_rdata,
  // Security byte store
  input wire logic [7:0] sec_nv_wdata,
  input wire logic sec_nv_we,
  output logic [7:0] sec_nv_value
);
  // Only 16 bytes are modelled; higher address bits alias
  logic [7:0] mem_r [16];
  // Last byte driven, inverted while the array is not read
  logic [7:0] last_r = 8'h00;
  // Store starts erased, as a blank part would
  logic [7:0] nv_r = 8'hFF;

  // Array and store updates
  always @(posedge clk)
  begin
    if (flash_erase)
      foreach (mem_r[i]) mem_r[i] <= 8'hFF;
    else if (flash_wr)
      mem_r[prog_req.addr[3:0]] <= prog_req.wdata;
    if (flash_rd)
      last_r <= flash_rdata;
    if (sec_nv_we)
      nv_r <= sec_nv_wdata;
  end

  // Idle bus shows a changed value so stale data never passes for a read
  assign flash_rdata = flash_rd ? mem_r[prog_req.addr[3:0]] : ~last_r;
  assign sec_nv_value = nv_r;
endmodule : prog_side_model
